/* pkg/ioc_pad_if.sv */
// Carrier for conditioned pad inputs from the synchroniser to the cell pair
`timescale 1ns/100ps
interface ioc_pad_if #(parameter int N = 2);
    logic [N-1:0] pad_now;
    logic [N-1:0] pad_dly;
    modport prod (output pad_now, output pad_dly);
    modport cons (input pad_now, input pad_dly);
endinterface

/* pkg/ioc_pkg.sv */
// Constants, configuration layout and reset values for the I/O cell pair
package ioc_pkg;

    localparam int NUM_SLICES  = 2;
    localparam int SYNC_STAGES = 3;
    localparam int DLY_STAGES  = 2;
    localparam int STAT_BITS   = 3;

    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;

    localparam logic [ADDR_W-1:0] A_CFG0 = 4'h0;
    localparam logic [ADDR_W-1:0] A_CFG1 = 4'h1;
    localparam logic [ADDR_W-1:0] A_GLB  = 4'h2;
    localparam logic [ADDR_W-1:0] A_STAT = 4'h3;

    // Reserved bits are dropped on write so they always read zero
    localparam logic [DATA_W-1:0] CFG_WMASK = 16'h03FF;
    localparam logic [DATA_W-1:0] GLB_WMASK = 16'h0001;
    localparam logic [DATA_W-1:0] CFG_RST   = 16'h0000;
    localparam logic              GSR_HI_RST = 1'b1;

    // Source of routed data B
    localparam logic [1:0] SEL_FT   = 2'h0;
    localparam logic [1:0] SEL_BYP  = 2'h1;
    localparam logic [1:0] SEL_REGQ = 2'h2;
    localparam logic [1:0] SEL_SER  = 2'h3;

    typedef struct packed {
        logic [5:0] rsvd;
        logic       oe_set;
        logic       out_set;
        logic       in_set;
        logic [1:0] b_sel;
        logic       in_dly;
        logic       oe_latch;
        logic       out_latch;
        logic       in_latch;
        logic       clk_fall;
    } ioc_cfg_s;

endpackage

/* src/ioc_cell_pair.sv */
// I/O cell pair: two slices of input, output and output-enable registers
`timescale 1ns/100ps
module ioc_cell_pair #(
    parameter int NUM_SLICES = ioc_pkg::NUM_SLICES,
    parameter int DLY_STAGES = ioc_pkg::DLY_STAGES,
    parameter bit SERIAL_EN  = 1'b1
) (
    input  wire logic                        core_clk,
    input  wire logic                        rst_b,
    input  wire logic                        clk_en,
    input  wire logic [ioc_pkg::ADDR_W-1:0]  reg_addr,
    input  wire logic [ioc_pkg::DATA_W-1:0]  reg_wdata,
    input  wire logic                        reg_wr,
    input  wire logic                        reg_rd,
    output wire logic [ioc_pkg::DATA_W-1:0]  reg_rdata,
    input  wire logic [NUM_SLICES-1:0]       data_in,
    input  wire logic [NUM_SLICES-1:0]       feed_through,
    input  wire logic [NUM_SLICES-1:0]       slice_clk,
    input  wire logic [NUM_SLICES-1:0]       input_clock_enable,
    input  wire logic [NUM_SLICES-1:0]       input_set_reset,
    input  wire logic [NUM_SLICES-1:0]       output_clock_enable,
    input  wire logic [NUM_SLICES-1:0]       output_set_reset,
    input  wire logic [NUM_SLICES-1:0]       slice_output_enable,
    input  wire logic [NUM_SLICES-1:0]       slice_input_enable,
    input  wire logic [NUM_SLICES-1:0]       pad_in,
    input  wire logic                        global_set_reset,
    input  wire logic [NUM_SLICES-1:0]       serial_in_a,
    input  wire logic [NUM_SLICES-1:0]       serial_in_b,
    output wire logic [NUM_SLICES-1:0]       routed_data_a,
    output wire logic [NUM_SLICES-1:0]       routed_data_b,
    output wire logic [NUM_SLICES-1:0]       routed_oe,
    output wire logic [NUM_SLICES-1:0]       pad_out,
    output wire logic [NUM_SLICES-1:0]       pad_oe,
    output wire logic [NUM_SLICES-1:0]       serial_out,
    output wire logic [NUM_SLICES-1:0]       serial_oe,
    output wire logic [NUM_SLICES-1:0]       serial_pass
);
    import ioc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        ioc_cfg_s [NUM_SLICES-1:0] cfg;
        logic                      gsr_hi;
        logic [NUM_SLICES-1:0]     clk_prev;
        logic [NUM_SLICES-1:0]     in_q;
        logic [NUM_SLICES-1:0]     out_q;
        logic [NUM_SLICES-1:0]     oe_q;
        logic [DATA_W-1:0]         rd_data;
    } ioc_state_s;

    ioc_state_s st_r;
    ioc_state_s st_nxt;

    logic                  gsr_act;
    logic [NUM_SLICES-1:0] clk_eff;
    logic [NUM_SLICES-1:0] clk_edge;
    logic [NUM_SLICES-1:0] in_sr;
    logic [NUM_SLICES-1:0] out_sr;
    logic [NUM_SLICES-1:0] pad_sel;
    logic [NUM_SLICES-1:0] in_d;
    logic [NUM_SLICES-1:0] in_vis;
    logic [NUM_SLICES-1:0] out_vis;
    logic [NUM_SLICES-1:0] oe_vis;
    logic [DATA_W-1:0]     stat_word;

    if (NUM_SLICES != 2 || DLY_STAGES < 1) begin : g_chk
        $error("ioc_cell_pair: two slices and at least one delay stage");
    end

    // Every check below runs on the core clock and rests while reset is held
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    ////////////////////////////////////////////////////////////////////////////
    // Pad input conditioning

    ioc_pad_if #(.N(NUM_SLICES)) pads ();

    ioc_pad_sync #(
        .N   (NUM_SLICES),
        .DLY (DLY_STAGES)
    ) u_pad_sync (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .clk_en   (clk_en),
        .pad_raw  (pad_in),
        .pads     (pads.prod)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Global set/reset polarity

    assign gsr_act = st_r.gsr_hi ? global_set_reset : ~global_set_reset;

    ////////////////////////////////////////////////////////////////////////////
    // Per-slice steering

    for (genvar g = 0; g < NUM_SLICES; g++) begin : g_slice
        assign clk_eff[g]  = slice_clk[g] ^ st_r.cfg[g].clk_fall;
        assign clk_edge[g] = clk_eff[g] & ~st_r.clk_prev[g];
        assign in_sr[g]    = gsr_act | input_set_reset[g];
        assign out_sr[g]   = gsr_act | output_set_reset[g];

        assign pad_sel[g] = st_r.cfg[g].in_dly ? pads.pad_dly[g] : pads.pad_now[g];
        // Input enable low keeps stray pad activity out of the input register
        assign in_d[g]    = pad_sel[g] & slice_input_enable[g];

        // Set/reset overrides the stored bit at once, without waiting for an edge
        assign in_vis[g]  = in_sr[g] ? st_r.cfg[g].in_set : st_r.in_q[g];
        assign out_vis[g] = out_sr[g] ? st_r.cfg[g].out_set : st_r.out_q[g];
        assign oe_vis[g]  = out_sr[g] ? st_r.cfg[g].oe_set : st_r.oe_q[g];

        assign routed_data_a[g] = in_vis[g];
        assign routed_data_b[g] = (st_r.cfg[g].b_sel == SEL_FT)   ? feed_through[g] :
                                  (st_r.cfg[g].b_sel == SEL_BYP)  ? in_d[g] :
                                  (st_r.cfg[g].b_sel == SEL_REGQ) ? in_vis[g] :
                                  (SERIAL_EN & serial_in_b[g]);
        assign routed_oe[g] = oe_vis[g];
        assign pad_out[g]   = out_vis[g];
        assign pad_oe[g]    = oe_vis[g];

        // Serial out and enable taps mirror the pad drive, serial_pass follows serial_in_a; absent serial block leaves all three low
        assign serial_out[g]  = SERIAL_EN & out_vis[g];
        assign serial_oe[g]   = SERIAL_EN & oe_vis[g];
        assign serial_pass[g] = SERIAL_EN & serial_in_a[g];

        assign stat_word[STAT_BITS*g +: STAT_BITS] = {oe_vis[g], out_vis[g], in_vis[g]};

        ////////////////////////////////////////////////////////////////////////
        // Checks on this slice

        serial_mirror_a: assert property (
            SERIAL_EN |-> (serial_out[g] == pad_out[g]) && (serial_oe[g] == pad_oe[g]))
            else $error("serial taps differ from pad drive");

        pass_through_a: assert property (
            SERIAL_EN |-> serial_pass[g] == serial_in_a[g])
            else $error("serial pass does not follow its input");

        b_select_a: assert property (
            (st_r.cfg[g].b_sel == SEL_FT |-> routed_data_b[g] == feed_through[g]) and
            (st_r.cfg[g].b_sel == SEL_REGQ |-> routed_data_b[g] == routed_data_a[g]))
            else $error("routed data B from wrong source");

        delay_path_a: assert property (
            st_r.cfg[g].in_dly |-> pad_sel[g] == pads.pad_dly[g])
            else $error("delay option not applied");

        sr_force_a: assert property (
            output_set_reset[g] |-> pad_out[g] == st_r.cfg[g].out_set
                                 && routed_oe[g] == st_r.cfg[g].oe_set)
            else $error("output set/reset did not force output pair");

        gsr_polarity_a: assert property (
            (!st_r.gsr_hi && !global_set_reset) |-> routed_data_a[g] == st_r.cfg[g].in_set)
            else $error("active-low global set/reset ignored");

        sr_state_load_a: assert property (
            (clk_en && in_sr[g]) |=> st_r.in_q[g] == $past(st_r.cfg[g].in_set))
            else $error("set/reset did not load the input register");

        edge_capture_a: assert property (
            (clk_en && !out_sr[g] && !st_r.cfg[g].out_latch && output_clock_enable[g] && clk_edge[g])
            |=> st_r.out_q[g] == $past(data_in[g]))
            else $error("flip-flop missed active edge");

        no_edge_hold_a: assert property (
            (clk_en && !out_sr[g] && !st_r.cfg[g].oe_latch && !clk_edge[g]) |=> $stable(st_r.oe_q[g]))
            else $error("flip-flop changed without active edge");

        latch_pass_a: assert property (
            (clk_en && !in_sr[g] && st_r.cfg[g].in_latch && clk_eff[g] && input_clock_enable[g])
            ##1 (clk_en && !in_sr[g] && clk_eff[g] && input_clock_enable[g])
            |=> st_r.in_q[g] == $past(in_d[g]))
            else $error("latch not transparent at active level");

        enable_hold_a: assert property (
            (clk_en && !out_sr[g] && !output_clock_enable[g]) |=> $stable(st_r.out_q[g]))
            else $error("output register moved with enable low");

        // A stored bit moves only on set/reset or on an enabled capture
        in_enable_hold_a: assert property (
            (clk_en && !in_sr[g] && !input_clock_enable[g]) |=> $stable(st_r.in_q[g]))
            else $error("input register moved with enable low");

        latch_hold_a: assert property (
            (clk_en && !out_sr[g] && st_r.cfg[g].out_latch && !clk_eff[g]) |=> $stable(st_r.out_q[g]))
            else $error("closed latch let data through");

        oe_capture_a: assert property (
            (clk_en && !out_sr[g] && !st_r.cfg[g].oe_latch && output_clock_enable[g] && clk_edge[g])
            |=> st_r.oe_q[g] == $past(slice_output_enable[g]))
            else $error("enable flip-flop missed active edge");

        out_sr_load_a: assert property (
            (clk_en && out_sr[g]) |=> st_r.out_q[g] == $past(st_r.cfg[g].out_set)
                                   && st_r.oe_q[g] == $past(st_r.cfg[g].oe_set))
            else $error("output set/reset did not load the output pair");

        latch_cov: cover property (st_r.cfg[g].in_latch && clk_eff[g] && input_clock_enable[g] && clk_en);
        edge_cov: cover property (clk_edge[g] && output_clock_enable[g] && !out_sr[g] && clk_en);
        gsr_cov: cover property (gsr_act && st_r.gsr_hi);
        serial_cov: cover property (st_r.cfg[g].b_sel == SEL_SER && serial_in_b[g]);
    end

    assign stat_word[DATA_W-1:STAT_BITS*NUM_SLICES] = '0;

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        st_nxt = st_r;
        if (clk_en) begin
            if (reg_wr) begin
                case (reg_addr)
                    A_CFG0: begin
                        st_nxt.cfg[0] = ioc_cfg_s'(reg_wdata & CFG_WMASK);
                    end
                    A_CFG1: begin
                        st_nxt.cfg[1] = ioc_cfg_s'(reg_wdata & CFG_WMASK);
                    end
                    A_GLB: begin
                        st_nxt.gsr_hi = |(reg_wdata & GLB_WMASK);
                    end
                    default: begin
                    end
                endcase
            end
            // Read data stands for one enabled cycle only, holding while clk_en is low; unmapped addresses read zero
            st_nxt.rd_data = '0;
            if (reg_rd) begin
                case (reg_addr)
                    A_CFG0: st_nxt.rd_data = st_r.cfg[0];
                    A_CFG1: st_nxt.rd_data = st_r.cfg[1];
                    A_GLB: st_nxt.rd_data = {{(DATA_W-1){1'b0}}, st_r.gsr_hi};
                    A_STAT: st_nxt.rd_data = stat_word;
                    default: st_nxt.rd_data = '0;
                endcase
            end
            // Slice clock is routed logic on core_clk, so it is sampled directly
            for (int i = 0; i < NUM_SLICES; i++) begin
                st_nxt.clk_prev[i] = clk_eff[i];
                if (in_sr[i]) begin
                    st_nxt.in_q[i] = st_r.cfg[i].in_set;
                end else if (input_clock_enable[i] &&
                             (st_r.cfg[i].in_latch ? clk_eff[i] : clk_edge[i])) begin
                    st_nxt.in_q[i] = in_d[i];
                end
                if (out_sr[i]) begin
                    st_nxt.out_q[i] = st_r.cfg[i].out_set;
                    st_nxt.oe_q[i]  = st_r.cfg[i].oe_set;
                end else if (output_clock_enable[i]) begin
                    if (st_r.cfg[i].out_latch ? clk_eff[i] : clk_edge[i]) begin
                        st_nxt.out_q[i] = data_in[i];
                    end
                    if (st_r.cfg[i].oe_latch ? clk_eff[i] : clk_edge[i]) begin
                        st_nxt.oe_q[i] = slice_output_enable[i];
                    end
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_r        <= '0;
            st_r.gsr_hi <= GSR_HI_RST;
            st_r.cfg    <= {NUM_SLICES{CFG_RST}};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign reg_rdata = st_r.rd_data;

    ////////////////////////////////////////////////////////////////////////////
    // Register port checks

    read_latency_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        (clk_en && reg_rd && reg_addr == A_GLB) |=> reg_rdata[0] == $past(st_r.gsr_hi))
        else $error("global config read not returned next cycle");

    // Overrides stay combinational while frozen; only stored bits must hold
    freeze_hold_a: assert property (
        !clk_en |=> $stable(st_r.in_q) && $stable(st_r.out_q) && $stable(st_r.oe_q))
        else $error("slice state moved while the clock enable was low");

    cfg_write_a: assert property (
        (clk_en && reg_wr && reg_addr == A_CFG1) |=> st_r.cfg[1] == ($past(reg_wdata) & CFG_WMASK))
        else $error("configuration write not stored with reserved bits cleared");

    glb_write_a: assert property (
        (clk_en && reg_wr && reg_addr == A_GLB) |=> st_r.gsr_hi == $past(reg_wdata[0]))
        else $error("global polarity write not stored");

    read_cov: cover property (@(posedge core_clk) disable iff (!rst_b)
        reg_rd && reg_addr == A_STAT ##1 reg_rdata != '0);

endmodule

/* src/ioc_pad_sync.sv */
// Pad input synchroniser, deglitch and selectable delay line
`timescale 1ns/100ps
module ioc_pad_sync #(
    parameter int N   = ioc_pkg::NUM_SLICES,
    parameter int DLY = ioc_pkg::DLY_STAGES
) (
    input  wire logic         core_clk,
    input  wire logic         rst_b,
    input  wire logic         clk_en,
    input  wire logic [N-1:0] pad_raw,
    ioc_pad_if.prod           pads
);
    import ioc_pkg::*;

    typedef struct packed {
        logic [SYNC_STAGES-1:0][N-1:0] sync;
        logic [N-1:0]                  clean;
        logic [DLY-1:0][N-1:0]         dly;
    } ioc_sync_s;

    ioc_sync_s st_r;
    ioc_sync_s st_nxt;
    logic [N-1:0] agree;

    if (DLY < 1 || SYNC_STAGES < 3) begin : g_chk
        $error("ioc_pad_sync: delay needs one stage and sync three");
    end

    // Only the second and third stages are compared; the first feeds the second alone
    assign agree = ~(st_r.sync[1] ^ st_r.sync[2]);

    always_comb begin
        st_nxt = st_r;
        if (clk_en) begin
            st_nxt.sync[0] = pad_raw;
            for (int k = 1; k < SYNC_STAGES; k++) begin
                st_nxt.sync[k] = st_r.sync[k-1];
            end
            st_nxt.clean = (st_r.clean & ~agree) | (st_r.sync[1] & agree);
            // Delay element trades latency for hold margin on slow sources
            st_nxt.dly[0] = st_r.clean;
            for (int k = 1; k < DLY; k++) begin
                st_nxt.dly[k] = st_r.dly[k-1];
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign pads.pad_now = st_r.clean;
    assign pads.pad_dly = st_r.dly[DLY-1];

endmodule

/* verification/ioc_pad_model.sv */
// Pad buffer model: resolves the pad wire from the cell and an outside driver
`timescale 1ns/100ps
module ioc_pad_model (
    input  wire logic [1:0] pad_out,
    input  wire logic [1:0] pad_oe,
    input  wire logic       ext_en,
    input  wire logic [1:0] ext_val,
    output wire logic [1:0] pad_in
);
    ////////////////////////////////////////////////////////////////////////////
    // The cell wins a contention; an undriven pad sits at the keeper's pull-up
    assign pad_in = (pad_oe & pad_out) | (~pad_oe & (ext_en ? ext_val : 2'b11));
endmodule

/* verification/tb_top.sv */
// Self-checking bench for the I/O cell pair
`timescale 1ns/100ps
`define CHK(what, exp, got) begin checked++; if ((got) !== (exp)) begin fail_count++; \
    $display("unexpected %s: expected %0h seen %0h", what, exp, got); end end
module tb_top;
    import ioc_pkg::*;
    localparam int DLY = 3;
    logic              core_clk = 1'b0;
    logic              rst_b = 1'b0;
    logic              clk_en = 1'b1;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [DATA_W-1:0] reg_wdata = '0;
    logic              reg_wr = 1'b0;
    logic              reg_rd = 1'b0;
    logic [DATA_W-1:0] reg_rdata;
    logic [1:0]        data_in = '0, feed_through = '0, slice_clk = '0, input_clock_enable = '0;
    logic [1:0]        input_set_reset = '0, output_clock_enable = '0, output_set_reset = '0;
    logic [1:0]        slice_output_enable = '0, slice_input_enable = '0, serial_in_a = '0;
    logic [1:0]        serial_in_b = '0, ext_val = '0, pad_in;
    logic              global_set_reset = 1'b0;
    logic [1:0]        routed_data_a, routed_data_b, routed_oe, pad_out, pad_oe;
    logic [1:0]        serial_out, serial_oe, serial_pass;
    int                fail_count = 0;
    int                checked = 0;
    ioc_cfg_s          c;

    always #12.5 core_clk = ~core_clk;

    ioc_cell_pair #(.DLY_STAGES(DLY)) dut (
        .core_clk(core_clk), .rst_b(rst_b), .clk_en(clk_en), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .data_in(data_in), .feed_through(feed_through), .slice_clk(slice_clk),
        .input_clock_enable(input_clock_enable), .input_set_reset(input_set_reset),
        .output_clock_enable(output_clock_enable), .output_set_reset(output_set_reset),
        .slice_output_enable(slice_output_enable), .slice_input_enable(slice_input_enable),
        .pad_in(pad_in), .global_set_reset(global_set_reset), .serial_in_a(serial_in_a),
        .serial_in_b(serial_in_b), .routed_data_a(routed_data_a), .routed_data_b(routed_data_b),
        .routed_oe(routed_oe), .pad_out(pad_out), .pad_oe(pad_oe), .serial_out(serial_out),
        .serial_oe(serial_oe), .serial_pass(serial_pass));

    ioc_pad_model pads (.pad_out(pad_out), .pad_oe(pad_oe), .ext_en(1'b1), .ext_val(ext_val),
        .pad_in(pad_in));

    ////////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge core_clk);
        @(negedge core_clk);
    endtask

    task automatic do_reset();
        @(posedge core_clk);
        rst_b <= 1'b0;
        {data_in, feed_through, slice_clk, input_clock_enable, input_set_reset, output_clock_enable,
         output_set_reset, slice_output_enable, slice_input_enable, serial_in_a, serial_in_b,
         ext_val} <= '0;
        global_set_reset <= 1'b0;
        repeat (5) @(posedge core_clk);
        rst_b <= 1'b1;
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    // Read data stand only in the enabled cycle after the strobe
    task automatic rchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(negedge core_clk);
        `CHK("reg_rdata", e, reg_rdata)
    endtask

    task automatic pulse(input int i);
        @(posedge core_clk);
        slice_clk[i] <= 1'b1;
        repeat (2) @(posedge core_clk);
        slice_clk[i] <= 1'b0;
        settle(2);
    endtask

    // Cycles until routed data B of slice 0 shows v; a hang ends the run
    task automatic lat(input logic v, output int n);
        n = 0;
        @(negedge core_clk);
        while (routed_data_b[0] !== v && n < 40) begin
            @(negedge core_clk);
            n++;
        end
        if (n >= 40) begin
            fail_count++;
            $display("unexpected routed_data_b: expected %0h seen %0h", v, routed_data_b[0]);
            tally_and_finish();
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic test_regs();
        do_reset();
        rchk(A_CFG0, CFG_RST);
        rchk(A_CFG1, CFG_RST);
        rchk(A_GLB, 16'h0001);
        rchk(4'hF, 16'h0000);
        wr(A_CFG1, 16'hFFFF);
        rchk(A_CFG1, CFG_WMASK);
        wr(A_STAT, 16'hFFFF);
        rchk(A_STAT, 16'h0000);
        $display("test regs done");
    endtask

    task automatic test_out();
        do_reset();
        @(posedge core_clk);
        output_clock_enable <= 2'b11;
        data_in <= 2'b01;
        slice_output_enable <= 2'b01;
        pulse(0);
        `CHK("pad_out", 1'b1, pad_out[0])
        `CHK("pad_oe", 2'b01, pad_oe)
        `CHK("routed_oe", 2'b01, routed_oe)
        `CHK("serial", {pad_oe, pad_out}, {serial_oe, serial_out})
        @(posedge core_clk);
        output_clock_enable[0] <= 1'b0;
        data_in[0] <= 1'b0;
        pulse(0);
        `CHK("pad_out held", 1'b1, pad_out[0])
        @(posedge core_clk);
        output_clock_enable[0] <= 1'b1;
        data_in[0] <= 1'b1;
        slice_clk[0] <= 1'b1;
        settle(3);
        @(posedge core_clk);
        data_in[0] <= 1'b0;
        settle(3);
        `CHK("edge only", 1'b1, pad_out[0])
        c = '0;
        c.out_latch = 1'b1;
        wr(A_CFG0, c);
        settle(3);
        `CHK("latch open", 1'b0, pad_out[0])
        @(posedge core_clk);
        slice_clk[0] <= 1'b0;
        settle(2);
        @(posedge core_clk);
        data_in[0] <= 1'b1;
        settle(3);
        `CHK("latch shut", 1'b0, pad_out[0])
        c = '0;
        c.clk_fall = 1'b1;
        wr(A_CFG1, c);
        @(posedge core_clk);
        data_in[1] <= 1'b1;
        slice_clk[1] <= 1'b1;
        settle(3);
        `CHK("rise ignored", 1'b0, pad_out[1])
        @(posedge core_clk);
        slice_clk[1] <= 1'b0;
        settle(3);
        `CHK("fall taken", 1'b1, pad_out[1])
        $display("test out done");
    endtask

    task automatic test_setrst();
        do_reset();
        c = '0;
        c.out_set = 1'b1;
        c.oe_set = 1'b1;
        c.in_set = 1'b1;
        wr(A_CFG0, c);
        @(posedge core_clk);
        output_set_reset[0] <= 1'b1;
        @(negedge core_clk);
        `CHK("osr now", 3'b110, {pad_out[0], pad_oe[0], routed_data_a[0]})
        @(posedge core_clk);
        output_set_reset[0] <= 1'b0;
        input_set_reset[0] <= 1'b1;
        @(negedge core_clk);
        `CHK("isr now", 1'b1, routed_data_a[0])
        do_reset();
        c = '0;
        c.out_set = 1'b1;
        wr(A_CFG1, c);
        @(posedge core_clk);
        global_set_reset <= 1'b1;
        @(negedge core_clk);
        `CHK("gsr high", 1'b1, pad_out[1])
        do_reset();
        wr(A_GLB, 16'h0000);
        global_set_reset <= 1'b1;
        wr(A_CFG1, c);
        settle(2);
        `CHK("gsr idle", 1'b0, pad_out[1])
        @(posedge core_clk);
        global_set_reset <= 1'b0;
        @(negedge core_clk);
        `CHK("gsr low", 1'b1, pad_out[1])
        $display("test setrst done");
    endtask

    task automatic test_freeze();
        do_reset();
        c = '0;
        c.in_latch = 1'b1;
        wr(A_CFG0, c);
        {input_clock_enable, slice_input_enable, output_clock_enable, data_in, ext_val} <= 10'h155;
        slice_clk[0] <= 1'b1;
        settle(8);
        `CHK("latch in", 1'b1, routed_data_a[0])
        rchk(A_STAT, 16'h0003);
        @(posedge core_clk);
        clk_en <= 1'b0;
        {data_in, ext_val, slice_clk} <= '0;
        settle(2);
        @(posedge core_clk);
        slice_clk[0] <= 1'b1;
        settle(8);
        `CHK("frozen", 2'b11, {routed_data_a[0], pad_out[0]})
        wr(A_GLB, 16'h0000);
        clk_en <= 1'b1;
        rchk(A_GLB, 16'h0001);
        $display("test freeze done");
    endtask

    task automatic test_mux();
        int n0;
        int n1;
        int n2;
        do_reset();
        @(posedge core_clk);
        feed_through <= 2'b01;
        serial_in_a <= 2'b10;
        @(negedge core_clk);
        `CHK("ft", 1'b1, routed_data_b[0])
        `CHK("pass", 2'b10, serial_pass)
        c = '0;
        c.b_sel = SEL_SER;
        wr(A_CFG0, c);
        serial_in_b <= 2'b01;
        feed_through <= 2'b00;
        settle(0);
        `CHK("ser", 1'b1, routed_data_b[0])
        c.b_sel = SEL_BYP;
        wr(A_CFG0, c);
        slice_input_enable[0] <= 1'b1;
        lat(1'b0, n0);
        @(posedge core_clk);
        ext_val[0] <= 1'b1;
        lat(1'b1, n0);
        @(posedge core_clk);
        ext_val[0] <= 1'b0;
        lat(1'b0, n1);
        c.in_dly = 1'b1;
        wr(A_CFG0, c);
        settle(2 * DLY);
        @(posedge core_clk);
        ext_val[0] <= 1'b1;
        lat(1'b1, n1);
        `CHK("delay", DLY, n1 - n0)
        c.b_sel = SEL_REGQ;
        wr(A_CFG0, c);
        input_clock_enable[0] <= 1'b1;
        pulse(0);
        `CHK("in reg", 2'b11, {routed_data_a[0], routed_data_b[0]})
        c.b_sel = SEL_BYP;
        wr(A_CFG0, c);
        slice_input_enable[0] <= 1'b0;
        lat(1'b0, n2);
        `CHK("gated", 1'b0, routed_data_b[0])
        $display("test mux done");
    endtask

    initial begin
        test_regs();
        test_out();
        test_setrst();
        test_freeze();
        test_mux();
        tally_and_finish();
    end
endmodule
